// ==== buck3_defines.svh ====
// Offsets, field positions, reset values and voltage-map figures of the bank.
`ifndef BUCK3_DEFINES_SVH
`define BUCK3_DEFINES_SVH

`define BUCK_A_RUN_OFS 8'h3c
`define BUCK_A_STBY_OFS 8'h3d
`define BUCK_A_SLEEP_OFS 8'h3e
`define BUCK_A_MODE_OFS 8'h3f
`define BUCK_A_TUNE_OFS 8'h40
`define BUCK_B_RUN_OFS 8'h43
`define BUCK_B_STBY_OFS 8'h44
`define BUCK_B_SLEEP_OFS 8'h45
`define BUCK_B_MODE_OFS 8'h46
`define BUCK_B_TUNE_OFS 8'h47

`define SLOT_RUN 3'h0
`define SLOT_STBY 3'h1
`define SLOT_SLEEP 3'h2
`define SLOT_MODE 3'h3
`define SLOT_TUNE 3'h4

`define CODE_MSB 5
`define RANGE_BIT 6
`define MODE_SEL_MSB 3
`define SLEEP_PFM_BIT 5

`define CODE_RST 6'h00
`define RANGE_RST 1'b0
`define MODE_RST 8'h00
`define TUNE_RST 8'h00
`define SETPOINT_MASK 8'h3f
`define MODE_MASK 8'h2f
`define TUNE_MASK 8'hff
`define RDATA_RST 8'h00

`define LOW_BASE_MV 12'd400
`define LOW_STEP_MV 12'd25
`define HIGH_BASE_MV 12'd800
`define HIGH_STEP_MV 12'd50
`define HIGH_LAST_STEP 6'd50

`endif

// ==== buck3_pkg.sv ====
// Types shared by the set point register bank.
package buck3_pkg;

    typedef enum logic [1:0] {
        PS_RUN,
        PS_STANDBY,
        PS_SLEEP
    } power_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [7:0] run;
        logic [7:0] standby;
        logic [7:0] sleep;
        logic [7:0] mode;
        logic [7:0] tuning;
    } chan_view_t;

    typedef struct packed {
        logic enable;
        logic [6:0] code;
        logic [11:0] target_mv;
        logic reserved;
        logic [3:0] mode;
        logic [7:0] tuning;
    } buck_drive_t;

endpackage : buck3_pkg

// ==== buck3_channel.sv ====
// Register storage of one converter output: set points, mode and tuning.
`timescale 1ns/100ps
`include "buck3_defines.svh"

module buck3_channel
    import buck3_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic srst,
    // Write strobe with its slot and data.
    input wire logic wr_en,
    input wire logic [2:0] wr_slot,
    input wire logic [7:0] wdata,
    // Configuration load of the range bit.
    input wire logic cfg_load,
    input wire logic cfg_range,
    // Register contents as they read back.
    output chan_view_t view
);

    logic [5:0] run_code_r, run_code_nxt;
    logic [5:0] stby_code_r, stby_code_nxt;
    logic [5:0] sleep_code_r, sleep_code_nxt;
    logic [7:0] mode_r, mode_nxt;
    logic [7:0] tune_r, tune_nxt;
    logic range_r, range_nxt;

    always_comb begin
        run_code_nxt = run_code_r;
        stby_code_nxt = stby_code_r;
        sleep_code_nxt = sleep_code_r;
        mode_nxt = mode_r;
        tune_nxt = tune_r;
        range_nxt = range_r;
        if (cfg_load) begin
            range_nxt = cfg_range;
        end
        if (wr_en) begin
            case (wr_slot)
                `SLOT_RUN: run_code_nxt = wdata[`CODE_MSB:0];
                `SLOT_STBY: stby_code_nxt = wdata[`CODE_MSB:0];
                `SLOT_SLEEP: sleep_code_nxt = wdata[`CODE_MSB:0];
                `SLOT_MODE: mode_nxt = wdata & `MODE_MASK;
                `SLOT_TUNE: tune_nxt = wdata & `TUNE_MASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            run_code_r <= `CODE_RST;
            stby_code_r <= `CODE_RST;
            sleep_code_r <= `CODE_RST;
            mode_r <= `MODE_RST;
            tune_r <= `TUNE_RST;
            range_r <= `RANGE_RST;
        end else begin
            run_code_r <= run_code_nxt;
            stby_code_r <= stby_code_nxt;
            sleep_code_r <= sleep_code_nxt;
            mode_r <= mode_nxt;
            tune_r <= tune_nxt;
            range_r <= range_nxt;
        end
    end

    // Every set point shows the one range bit; bit 7 of a set point always reads zero.
    assign view.run = {1'b0, range_r, run_code_r};
    assign view.standby = {1'b0, range_r, stby_code_r};
    assign view.sleep = {1'b0, range_r, sleep_code_r};
    assign view.mode = mode_r;
    assign view.tuning = tune_r;

endmodule : buck3_channel

// ==== buck3_setpoint_register_bank.sv ====
// Set point register bank for the paired buck outputs A and B.
`timescale 1ns/100ps
`include "buck3_defines.svh"

// Operation
// - Output A run set point bits 5:0 are writable and reset to zero.
// - Run set point bit 6 is the range, read-only, set at configuration.
// - Output A standby set point bits 5:0 are writable, reset to zero.
// - Standby bit 6 copies the run range bit at configuration load.
// - Output A sleep set point is decoded at its own address.
// - Each output has a switching mode selector at its own address.
// - Each output has a tuning register at its own address.
// - Output B run and standby set points sit at consecutive addresses.
// - Output B sleep set point follows its standby register.
// - Low range: 400 mV at code zero, plus 25 mV per step.
module buck3_setpoint_register_bank
    import buck3_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic srst,
    // Register access from the serial control port.
    input reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rd_valid,
    // Configuration load of the range bits.
    input wire logic cfg_load,
    input wire logic cfg_range_a,
    input wire logic cfg_range_b,
    // Operating state of the device.
    input power_state_t power_state,
    input wire logic single_phase,
    // Converter drive values.
    output buck_drive_t buck_a_out,
    output buck_drive_t buck_b_out
);

    chan_view_t a_view;
    chan_view_t b_view;
    logic a_hit;
    logic b_hit;
    logic [2:0] a_slot;
    logic [2:0] b_slot;
    logic [7:0] rd_value;
    logic [7:0] rdata_r, rdata_nxt;
    logic rd_valid_r, rd_valid_nxt;
    buck_drive_t a_out_r, a_out_nxt;
    buck_drive_t b_out_r, b_out_nxt;

    function automatic logic [11:0] code_to_mv(input logic [6:0] code);
        logic [11:0] step;
        step = {6'h00, code[`CODE_MSB:0]};
        if (code[`RANGE_BIT]) begin
            code_to_mv = `HIGH_BASE_MV + `HIGH_STEP_MV * step;
        end else begin
            code_to_mv = `LOW_BASE_MV + `LOW_STEP_MV * step;
        end
    endfunction : code_to_mv

    function automatic buck_drive_t make_drive(input chan_view_t v,
                                               input power_state_t ps);
        logic [7:0] sel;
        sel = v.run;
        make_drive.enable = 1'b1;
        case (ps)
            PS_RUN: sel = v.run;
            PS_STANDBY: sel = v.standby;
            PS_SLEEP: begin
                sel = v.sleep;
                make_drive.enable = v.mode[`SLEEP_PFM_BIT];
            end
            default: sel = v.run;
        endcase
        make_drive.code = sel[6:0];
        make_drive.reserved = sel[`RANGE_BIT] &&
            (sel[`CODE_MSB:0] > `HIGH_LAST_STEP);
        make_drive.target_mv = make_drive.reserved ? 12'h000 :
            code_to_mv(sel[6:0]);
        make_drive.mode = v.mode[`MODE_SEL_MSB:0];
        make_drive.tuning = v.tuning;
    endfunction : make_drive

    // Address decode of the two register groups.
    always_comb begin
        a_hit = 1'b1;
        b_hit = 1'b1;
        a_slot = `SLOT_RUN;
        b_slot = `SLOT_RUN;
        case (reg_req.addr)
            `BUCK_A_RUN_OFS: a_slot = `SLOT_RUN;
            `BUCK_A_STBY_OFS: a_slot = `SLOT_STBY;
            `BUCK_A_SLEEP_OFS: a_slot = `SLOT_SLEEP;
            `BUCK_A_MODE_OFS: a_slot = `SLOT_MODE;
            `BUCK_A_TUNE_OFS: a_slot = `SLOT_TUNE;
            default: a_hit = 1'b0;
        endcase
        case (reg_req.addr)
            `BUCK_B_RUN_OFS: b_slot = `SLOT_RUN;
            `BUCK_B_STBY_OFS: b_slot = `SLOT_STBY;
            `BUCK_B_SLEEP_OFS: b_slot = `SLOT_SLEEP;
            `BUCK_B_MODE_OFS: b_slot = `SLOT_MODE;
            `BUCK_B_TUNE_OFS: b_slot = `SLOT_TUNE;
            default: b_hit = 1'b0;
        endcase
    end

    buck3_channel u_chan_a (
        .core_clk(core_clk),
        .srst(srst),
        .wr_en(reg_req.wr && a_hit),
        .wr_slot(a_slot),
        .wdata(reg_req.wdata),
        .cfg_load(cfg_load),
        .cfg_range(cfg_range_a),
        .view(a_view)
    );

    buck3_channel u_chan_b (
        .core_clk(core_clk),
        .srst(srst),
        .wr_en(reg_req.wr && b_hit),
        .wr_slot(b_slot),
        .wdata(reg_req.wdata),
        .cfg_load(cfg_load),
        .cfg_range(cfg_range_b),
        .view(b_view)
    );

    // Read multiplexer; an unmapped address reads zero.
    always_comb begin
        case (reg_req.addr)
            `BUCK_A_RUN_OFS: rd_value = a_view.run;
            `BUCK_A_STBY_OFS: rd_value = a_view.standby;
            `BUCK_A_SLEEP_OFS: rd_value = a_view.sleep;
            `BUCK_A_MODE_OFS: rd_value = a_view.mode;
            `BUCK_A_TUNE_OFS: rd_value = a_view.tuning;
            `BUCK_B_RUN_OFS: rd_value = b_view.run;
            `BUCK_B_STBY_OFS: rd_value = b_view.standby;
            `BUCK_B_SLEEP_OFS: rd_value = b_view.sleep;
            `BUCK_B_MODE_OFS: rd_value = b_view.mode;
            `BUCK_B_TUNE_OFS: rd_value = b_view.tuning;
            default: rd_value = `RDATA_RST;
        endcase
    end

    always_comb begin
        rdata_nxt = rdata_r;
        rd_valid_nxt = reg_req.rd;
        if (reg_req.rd) begin
            rdata_nxt = rd_value;
        end
    end

    // Drive values follow the power state; single phase runs B from A.
    always_comb begin
        a_out_nxt = make_drive(a_view, power_state);
        if (single_phase) begin
            b_out_nxt = make_drive(a_view, power_state);
        end else begin
            b_out_nxt = make_drive(b_view, power_state);
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rdata_r <= `RDATA_RST;
            rd_valid_r <= 1'b0;
            a_out_r <= '0;
            b_out_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
            rd_valid_r <= rd_valid_nxt;
            a_out_r <= a_out_nxt;
            b_out_r <= b_out_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign reg_rd_valid = rd_valid_r;
    assign buck_a_out = a_out_r;
    assign buck_b_out = b_out_r;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    property p_run_write;
        reg_req.wr && reg_req.addr == `BUCK_A_RUN_OFS
        |=> a_view.run[5:0] == $past(reg_req.wdata[5:0]);
    endproperty
    a_run_write: assert property (p_run_write)
        else $error("run set point A did not take the write");

    property p_range_hold;
        !cfg_load |=> $stable(a_view.run[6]) && $stable(b_view.run[6]);
    endproperty
    a_range_hold: assert property (p_range_hold)
        else $error("range bit changed without a configuration load");

    property p_stby_write;
        reg_req.wr && reg_req.addr == `BUCK_A_STBY_OFS
        |=> a_view.standby[5:0] == $past(reg_req.wdata[5:0]);
    endproperty
    a_stby_write: assert property (p_stby_write)
        else $error("standby set point A did not take the write");

    property p_range_copy;
        cfg_load |=> a_view.standby[6] == $past(cfg_range_a) &&
            a_view.run[6] == a_view.standby[6] &&
            b_view.standby[6] == $past(cfg_range_b);
    endproperty
    a_range_copy: assert property (p_range_copy)
        else $error("standby range bit is not the run range bit");

    property p_sleep_a_read;
        reg_req.rd && reg_req.addr == `BUCK_A_SLEEP_OFS
        |=> reg_rd_valid && reg_rdata == $past(a_view.sleep);
    endproperty
    a_sleep_a_read: assert property (p_sleep_a_read)
        else $error("sleep set point A read back wrong");

    property p_mode_read;
        reg_req.rd && reg_req.addr == `BUCK_B_MODE_OFS
        |=> reg_rdata == $past(b_view.mode);
    endproperty
    a_mode_read: assert property (p_mode_read)
        else $error("mode selector B read back wrong");

    property p_tune_write_read;
        reg_req.wr && reg_req.addr == `BUCK_A_TUNE_OFS && !reg_req.rd
        ##1 !reg_req.wr
        ##1 reg_req.rd && !reg_req.wr && reg_req.addr == `BUCK_A_TUNE_OFS
        |=> reg_rdata == $past(reg_req.wdata, 3);
    endproperty
    a_tune_write_read: assert property (p_tune_write_read)
        else $error("tuning register A did not return its write");

    property p_b_stby_read;
        reg_req.rd && reg_req.addr == `BUCK_B_STBY_OFS
        |=> reg_rdata == $past(b_view.standby);
    endproperty
    a_b_stby_read: assert property (p_b_stby_read)
        else $error("standby set point B read back wrong");

    property p_b_sleep_read;
        reg_req.rd && reg_req.addr == `BUCK_B_SLEEP_OFS
        |=> reg_rdata == $past(b_view.sleep);
    endproperty
    a_b_sleep_read: assert property (p_b_sleep_read)
        else $error("sleep set point B read back wrong");

    // The first cycle after reset still shows the cleared drive word.
    property p_low_map;
        !$past(srst) && !buck_a_out.code[6] |-> buck_a_out.target_mv ==
            12'(400 + 25 * buck_a_out.code[5:0]);
    endproperty
    a_low_map: assert property (p_low_map)
        else $error("low range voltage map is wrong");

    property p_high_map;
        buck_b_out.code[6] && !buck_b_out.reserved |->
            buck_b_out.code[5:0] <= 6'd50 && buck_b_out.target_mv ==
            12'(800 + 50 * buck_b_out.code[5:0]);
    endproperty
    a_high_map: assert property (p_high_map)
        else $error("high range voltage map is wrong");

    property p_bit7_zero;
        reg_rd_valid |-> !(reg_rdata[7] && ($past(reg_req.addr) !=
            `BUCK_A_TUNE_OFS) && ($past(reg_req.addr) != `BUCK_B_TUNE_OFS));
    endproperty
    a_bit7_zero: assert property (p_bit7_zero)
        else $error("bit 7 read back as one");

    property p_unmapped;
        reg_req.rd && !a_hit && !b_hit |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped address did not read zero");

    property p_rd_valid_pulse;
        1'b1 |=> reg_rd_valid == $past(reg_req.rd);
    endproperty
    a_rd_valid_pulse: assert property (p_rd_valid_pulse)
        else $error("read valid is not a one-cycle answer to a read");

    property p_sleep_enable;
        power_state == PS_SLEEP |=>
            buck_a_out.enable == $past(a_view.mode[`SLEEP_PFM_BIT]);
    endproperty
    a_sleep_enable: assert property (p_sleep_enable)
        else $error("sleep enable does not follow the mode bit");

    property p_single_phase;
        single_phase |=> buck_b_out == buck_a_out;
    endproperty
    a_single_phase: assert property (p_single_phase)
        else $error("output B does not follow output A in single phase");

    c_sleep_off: cover property (
        power_state == PS_SLEEP && !a_view.mode[5] ##1 !buck_a_out.enable);
    c_cfg_load_high: cover property (cfg_load && cfg_range_a
        ##1 a_view.run[6]);
    c_reserved_code: cover property (buck_b_out.reserved);
    c_unmapped_read: cover property (reg_req.rd && !a_hit && !b_hit);
    c_single_phase: cover property (single_phase && power_state == PS_RUN
        ##1 buck_b_out.code == buck_a_out.code);

endmodule : buck3_setpoint_register_bank

// ==== host_port_model.sv ====
// Host model that drives the register port of the set point bank.
`timescale 1ns/100ps
module host_port_model
    import buck3_pkg::*;
(
    // Clock.
    input wire logic core_clk,
    // Register access.
    output reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_valid
);
    initial begin
        reg_req = '0;
    end

    // Write pulse of one cycle; the range bit is left to configuration.
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge core_clk);
        reg_req <= '0;
    endtask : wr

    // Read pulse; the answer is taken one cycle after the request edge.
    task automatic rd(input logic [7:0] addr, output logic [7:0] data,
                      output logic valid);
        @(posedge core_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge core_clk);
        reg_req <= '0;
        #1;
        data = reg_rdata;
        valid = reg_rd_valid;
    endtask : rd
endmodule : host_port_model

// ==== buck3_setpoint_register_bank_test.sv ====
// Self-checking bench of the set point register bank.
`timescale 1ns/100ps
`include "buck3_defines.svh"
module buck3_setpoint_register_bank_test
    import buck3_pkg::*;
;
    logic core_clk;
    logic srst;
    logic cfg_load;
    logic cfg_range_a;
    logic cfg_range_b;
    logic single_phase;
    power_state_t power_state;
    reg_req_t reg_req;
    logic [7:0] reg_rdata;
    logic reg_rd_valid;
    buck_drive_t buck_a_out;
    buck_drive_t buck_b_out;
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    logic [7:0] addrs [10] = '{`BUCK_A_RUN_OFS, `BUCK_A_STBY_OFS,
        `BUCK_A_SLEEP_OFS, `BUCK_A_MODE_OFS, `BUCK_A_TUNE_OFS,
        `BUCK_B_RUN_OFS, `BUCK_B_STBY_OFS, `BUCK_B_SLEEP_OFS,
        `BUCK_B_MODE_OFS, `BUCK_B_TUNE_OFS};
    logic [7:0] masks [10] = '{8'h3f, 8'h3f, 8'h3f, 8'h2f, 8'hff,
        8'h3f, 8'h3f, 8'h3f, 8'h2f, 8'hff};
    logic [7:0] codes [5] = '{8'h18, 8'h1e, 8'h32, 8'h33, 8'h3f};

    buck3_setpoint_register_bank i_buck3_setpoint_register_bank (
        .core_clk(core_clk),
        .srst(srst),
        .reg_req(reg_req),
        .reg_rdata(reg_rdata),
        .reg_rd_valid(reg_rd_valid),
        .cfg_load(cfg_load),
        .cfg_range_a(cfg_range_a),
        .cfg_range_b(cfg_range_b),
        .power_state(power_state),
        .single_phase(single_phase),
        .buck_a_out(buck_a_out),
        .buck_b_out(buck_b_out)
    );

    host_port_model i_host_port_model (
        .core_clk(core_clk),
        .reg_req(reg_req),
        .reg_rdata(reg_rdata),
        .reg_rd_valid(reg_rd_valid)
    );

    task automatic end_sim;
        $display("Counts: %0d failures, %0d checks", failures, checks);
        if (failures == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp,
                            input string what);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp_byte

    task automatic cmp_drive(input buck_drive_t got, input buck_drive_t exp,
                             input string what);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp_drive

    // Reads one register and checks both the data and the valid pulse.
    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        i_host_port_model.rd(addr, d, v);
        cmp_byte({7'h00, v}, 8'h01, "read valid");
        cmp_byte(d, exp, "read data");
    endtask : rd_chk

    // Expected drive value worked out from the voltage map.
    function automatic buck_drive_t drv(input logic en, input logic [6:0] c,
                                        input logic [3:0] m,
                                        input logic [7:0] t);
        buck_drive_t d;
        d.enable = en;
        d.code = c;
        d.mode = m;
        d.tuning = t;
        d.reserved = c[6] && (c[5:0] > 6'd50);
        if (d.reserved) begin
            d.target_mv = 12'h000;
        end else if (c[6]) begin
            d.target_mv = 12'd800 + 12'd50 * c[5:0];
        end else begin
            d.target_mv = 12'd400 + 12'd25 * c[5:0];
        end
        return d;
    endfunction : drv

    task automatic settle;
        repeat (2) @(posedge core_clk);
        #1;
    endtask : settle

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            end_sim();
        end
    end

    initial begin
        srst = 1'b1;
        cfg_load = 1'b0;
        cfg_range_a = 1'b0;
        cfg_range_b = 1'b0;
        single_phase = 1'b0;
        power_state = PS_RUN;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        settle();
        cmp_drive(buck_a_out, drv(1'b1, 7'h00, 4'h0, 8'h00), "reset");
        for (int i = 0; i < 10; i++) begin
            rd_chk(addrs[i], 8'h00);
        end
        for (int i = 0; i < 10; i++) begin
            i_host_port_model.wr(addrs[i], 8'hff);
            rd_chk(addrs[i], masks[i]);
        end
        i_host_port_model.wr(8'h41, 8'hff);
        rd_chk(8'h41, 8'h00);
        rd_chk(8'h42, 8'h00);
        @(posedge core_clk);
        cfg_load <= 1'b1;
        cfg_range_a <= 1'b1;
        @(posedge core_clk);
        cfg_load <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            rd_chk(addrs[i], 8'h7f);
            rd_chk(addrs[i + 5], 8'h3f);
        end
        i_host_port_model.wr(`BUCK_A_RUN_OFS, 8'h98);
        rd_chk(`BUCK_A_RUN_OFS, 8'h58);
        for (int i = 0; i < 5; i++) begin
            i_host_port_model.wr(`BUCK_A_RUN_OFS, codes[i]);
            settle();
            cmp_drive(buck_a_out, drv(1'b1, {1'b1, codes[i][5:0]}, 4'hf,
                      8'hff), "run a");
        end
        cmp_drive(buck_b_out, drv(1'b1, 7'h3f, 4'hf, 8'hff), "run b");
        i_host_port_model.wr(`BUCK_A_STBY_OFS, 8'h1a);
        @(posedge core_clk);
        power_state <= PS_STANDBY;
        settle();
        cmp_drive(buck_a_out, drv(1'b1, 7'h5a, 4'hf, 8'hff), "stby");
        i_host_port_model.wr(`BUCK_A_SLEEP_OFS, 8'h19);
        @(posedge core_clk);
        power_state <= PS_SLEEP;
        settle();
        cmp_drive(buck_a_out, drv(1'b1, 7'h59, 4'hf, 8'hff), "sleep");
        i_host_port_model.wr(`BUCK_A_MODE_OFS, 8'h0f);
        settle();
        cmp_drive(buck_a_out, drv(1'b0, 7'h59, 4'hf, 8'hff), "off");
        @(posedge core_clk);
        single_phase <= 1'b1;
        settle();
        cmp_drive(buck_b_out, drv(1'b0, 7'h59, 4'hf, 8'hff), "pair");
        @(posedge core_clk);
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        rd_chk(`BUCK_A_RUN_OFS, 8'h00);
        end_sim();
    end
endmodule : buck3_setpoint_register_bank_test
